// ===== cise_alu.sv
`timescale 1ns/1ps
module cise_alu (
  input  wire cise_pkg::cise_op_t              i_op,
  input  wire logic [cise_pkg::ACC_W-1:0]      i_acc,
  input  wire logic [cise_pkg::ACC_W-1:0]      i_file,
  input  wire logic [cise_pkg::ACC_W-1:0]      i_lit,
  output logic      [cise_pkg::ACC_W-1:0]      o_result,
  output logic                                 o_carry,
  output logic                                 o_dcarry,
  output logic                                 o_zero
);
  logic [cise_pkg::ACC_W:0] sum9;
  logic [4:0]               nib;
  logic [cise_pkg::ACC_W-1:0] addend;

  always_comb begin
    addend = (i_op == cise_pkg::OP_ADD_LITERAL_TO_ACC) ? i_lit : i_file;
    sum9 = {1'b0, i_acc} + {1'b0, addend};
    nib  = {1'b0, i_acc[3:0]} + {1'b0, addend[3:0]};
    case (i_op)
      cise_pkg::OP_ADD_LITERAL_TO_ACC,
      cise_pkg::OP_ADD_ACC_AND_FILE:     o_result = sum9[7:0];
      cise_pkg::OP_AND_LITERAL_WITH_ACC: o_result = i_acc & i_lit;
      cise_pkg::OP_AND_ACC_WITH_FILE:    o_result = i_acc & i_file;
      cise_pkg::OP_OR_ACC_WITH_FILE:     o_result = i_acc | i_file;
      cise_pkg::OP_INCREMENT_FILE:       o_result = i_file + 8'h01;
      default:                           o_result = i_acc;
    endcase
    o_carry  = sum9[8];
    o_dcarry = nib[4];
    o_zero   = (o_result == 8'h00);
  end
endmodule

// ===== cise_core.sv
`timescale 1ns/1ps
module cise_core (
  input  wire logic                           i_ref_clk,
  input  wire logic                           i_rstn,
  input  wire logic                           i_psel,
  input  wire logic                           i_penable,
  input  wire logic                           i_pwrite,
  input  wire logic [7:0]                     i_paddr,
  input  wire logic [31:0]                    i_pwdata,
  output logic      [31:0]                    o_prdata,
  output logic                                o_pready,
  output logic                                o_pslverr,
  input  wire logic [cise_pkg::INSTR_W-1:0]   i_pm_data,
  output logic      [cise_pkg::PC_W-1:0]      o_pm_addr
);
  cise_pkg::cise_state_t              state, next_state;
  cise_pkg::cise_op_t                 op_q, next_op;
  logic                               bubble, next_bubble;
  logic                               run, next_run;
  logic [cise_pkg::PC_W-1:0]          pc, next_pc;
  logic [cise_pkg::INSTR_W-1:0]       instr, next_instr;
  logic [cise_pkg::ACC_W-1:0]         acc, next_acc;
  logic [cise_pkg::ACC_W-1:0]         opnd, next_opnd;
  logic [cise_pkg::ACC_W-1:0]         result, next_result;
  logic                               res_c, next_res_c;
  logic                               res_dc, next_res_dc;
  logic                               res_z, next_res_z;
  logic                               c, next_c;
  logic                               dc, next_dc;
  logic                               z, next_z;
  logic [cise_pkg::LATCH_W-1:0]       latch, next_latch;
  logic [cise_pkg::FADDR_W-1:0]       faddr, next_faddr;
  logic [cise_pkg::ACC_W-1:0]         file_mem [cise_pkg::FILE_DEPTH];
  logic                               mem_we;
  logic [cise_pkg::FADDR_W-1:0]       mem_wa;
  logic [cise_pkg::ACC_W-1:0]         mem_wd;
  logic [cise_pkg::ACC_W-1:0]         alu_result;
  logic                               alu_c;
  logic                               alu_dc;
  logic                               alu_z;
  logic [31:0]                        prdata, next_prdata;
  logic                               slverr, next_slverr;
  logic [31:0]                        rd_data;
  logic                               mapped;
  logic                               apb_wr;
  logic                               core_busy;
  logic [cise_pkg::FADDR_W-1:0]       fsel;

  function automatic cise_pkg::cise_op_t decode_op(input logic [cise_pkg::INSTR_W-1:0] w);
    cise_pkg::cise_op_t op;
    op = cise_pkg::OP_NONE;
    if (w[13:9] == cise_pkg::OPC_ADD_LIT)
      op = cise_pkg::OP_ADD_LITERAL_TO_ACC;
    else if (w[13:8] == cise_pkg::OPC_AND_LIT)
      op = cise_pkg::OP_AND_LITERAL_WITH_ACC;
    else if (w[13:8] == cise_pkg::OPC_ADD_FILE)
      op = cise_pkg::OP_ADD_ACC_AND_FILE;
    else if (w[13:8] == cise_pkg::OPC_AND_FILE)
      op = cise_pkg::OP_AND_ACC_WITH_FILE;
    else if (w[13:8] == cise_pkg::OPC_OR_FILE)
      op = cise_pkg::OP_OR_ACC_WITH_FILE;
    else if (w[13:8] == cise_pkg::OPC_INC_FILE)
      op = cise_pkg::OP_INCREMENT_FILE;
    else if (w[13:11] == cise_pkg::OPC_BRANCH)
      op = cise_pkg::OP_UNCONDITIONAL_BRANCH;
    return op;
  endfunction

  function automatic logic is_file_op(input cise_pkg::cise_op_t op);
    return (op == cise_pkg::OP_ADD_ACC_AND_FILE) || (op == cise_pkg::OP_AND_ACC_WITH_FILE) ||
           (op == cise_pkg::OP_OR_ACC_WITH_FILE) || (op == cise_pkg::OP_INCREMENT_FILE);
  endfunction

  cise_alu u_alu (
    .i_op     (op_q),
    .i_acc    (acc),
    .i_file   (opnd),
    .i_lit    (instr[cise_pkg::LIT_MSB:0]),
    .o_result (alu_result),
    .o_carry  (alu_c),
    .o_dcarry (alu_dc),
    .o_zero   (alu_z)
  );

  assign core_busy = (state != cise_pkg::ST_IDLE);
  assign fsel      = instr[cise_pkg::FADDR_MSB:0];
  assign o_pm_addr = pc;

  // register decode and read mux
  always_comb begin
    mapped  = 1'b1;
    rd_data = 32'h00000000;
    case (i_paddr)
      cise_pkg::REG_CTRL:   rd_data = 32'(run);
      cise_pkg::REG_ACC:    rd_data = 32'(acc);
      cise_pkg::REG_STATUS: rd_data = 32'({z, dc, c});
      cise_pkg::REG_PC:     rd_data = 32'(pc);
      cise_pkg::REG_LATCH:  rd_data = 32'(latch);
      cise_pkg::REG_FADDR:  rd_data = 32'(faddr);
      cise_pkg::REG_FDATA:  rd_data = 32'(file_mem[faddr]);
      cise_pkg::REG_INSTR:  rd_data = 32'(instr);
      default:              mapped  = 1'b0;
    endcase
  end

  assign o_pready  = i_psel & i_penable;
  assign apb_wr    = i_psel & i_penable & i_pwrite & mapped;
  assign o_prdata  = prdata;
  assign o_pslverr = slverr & o_pready;

  // bus answer is captured in the setup cycle
  always_comb begin
    next_prdata = prdata;
    next_slverr = slverr;
    if (i_psel && !i_penable) begin
      next_prdata = i_pwrite ? 32'h00000000 : rd_data;
      next_slverr = !mapped;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      prdata <= 32'h00000000;
      slverr <= 1'b0;
    end else begin
      prdata <= next_prdata;
      slverr <= next_slverr;
    end
  end

  // phase sequencer, datapath and software-visible state
  always_comb begin
    next_state  = state;
    next_op     = op_q;
    next_bubble = bubble;
    next_run    = run;
    next_pc     = pc;
    next_instr  = instr;
    next_acc    = acc;
    next_opnd   = opnd;
    next_result = result;
    next_res_c  = res_c;
    next_res_dc = res_dc;
    next_res_z  = res_z;
    next_c      = c;
    next_dc     = dc;
    next_z      = z;
    next_latch  = latch;
    next_faddr  = faddr;
    mem_we      = 1'b0;
    mem_wa      = faddr;
    mem_wd      = 8'h00;
    case (state)
      cise_pkg::ST_IDLE: begin
        if (run)
          next_state = cise_pkg::ST_Q1;
      end
      cise_pkg::ST_Q1: begin
        next_state = cise_pkg::ST_Q2;
        if (bubble) begin
          next_op = cise_pkg::OP_NONE;
        end else begin
          next_instr = i_pm_data;
          next_op    = decode_op(i_pm_data);
          next_pc    = pc + 13'h0001;
        end
      end
      cise_pkg::ST_Q2: begin
        next_state = cise_pkg::ST_Q3;
        next_opnd  = file_mem[fsel];
      end
      cise_pkg::ST_Q3: begin
        next_state  = cise_pkg::ST_Q4;
        next_result = alu_result;
        next_res_c  = alu_c;
        next_res_dc = alu_dc;
        next_res_z  = alu_z;
      end
      cise_pkg::ST_Q4: begin
        next_state  = run ? cise_pkg::ST_Q1 : cise_pkg::ST_IDLE;
        next_bubble = 1'b0;
        if (op_q == cise_pkg::OP_UNCONDITIONAL_BRANCH) begin
          next_pc     = {latch[cise_pkg::LATCH_HI:cise_pkg::LATCH_LO],
                         instr[cise_pkg::BR_MSB:0]};
          next_bubble = 1'b1;
        end else if (op_q != cise_pkg::OP_NONE) begin
          if (is_file_op(op_q) && instr[cise_pkg::DEST_BIT]) begin
            mem_we = 1'b1;
            mem_wa = fsel;
            mem_wd = result;
          end else begin
            next_acc = result;
          end
          next_z = res_z;
          if (op_q == cise_pkg::OP_ADD_LITERAL_TO_ACC || op_q == cise_pkg::OP_ADD_ACC_AND_FILE) begin
            next_c  = res_c;
            next_dc = res_dc;
          end
        end
      end
      default: next_state = cise_pkg::ST_IDLE;
    endcase
    if (apb_wr) begin
      case (i_paddr)
        cise_pkg::REG_CTRL:  next_run   = i_pwdata[cise_pkg::CTRL_RUN];
        cise_pkg::REG_LATCH: next_latch = i_pwdata[cise_pkg::LATCH_W-1:0];
        cise_pkg::REG_FADDR: next_faddr = i_pwdata[cise_pkg::FADDR_W-1:0];
        cise_pkg::REG_ACC: begin
          if (!core_busy)
            next_acc = i_pwdata[cise_pkg::ACC_W-1:0];
        end
        cise_pkg::REG_FDATA: begin
          if (!core_busy) begin
            mem_we = 1'b1;
            mem_wa = faddr;
            mem_wd = i_pwdata[cise_pkg::ACC_W-1:0];
          end
        end
        default: next_run = run;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state  <= cise_pkg::ST_IDLE;
      op_q   <= cise_pkg::OP_NONE;
      bubble <= 1'b0;
      run    <= 1'b0;
      pc     <= cise_pkg::PC_RST;
      instr  <= cise_pkg::INSTR_RST;
      acc    <= cise_pkg::ACC_RST;
      opnd   <= 8'h00;
      result <= 8'h00;
      res_c  <= 1'b0;
      res_dc <= 1'b0;
      res_z  <= 1'b0;
      c      <= 1'b0;
      dc     <= 1'b0;
      z      <= 1'b0;
      latch  <= cise_pkg::LATCH_RST;
      faddr  <= 7'h00;
      for (int i = 0; i < cise_pkg::FILE_DEPTH; i++)
        file_mem[i] <= 8'h00;
    end else begin
      state  <= next_state;
      op_q   <= next_op;
      bubble <= next_bubble;
      run    <= next_run;
      pc     <= next_pc;
      instr  <= next_instr;
      acc    <= next_acc;
      opnd   <= next_opnd;
      result <= next_result;
      res_c  <= next_res_c;
      res_dc <= next_res_dc;
      res_z  <= next_res_z;
      c      <= next_c;
      dc     <= next_dc;
      z      <= next_z;
      latch  <= next_latch;
      faddr  <= next_faddr;
      if (mem_we)
        file_mem[mem_wa] <= mem_wd;
    end
  end

  // checks
  logic [8:0] chk_sum9;
  logic [4:0] chk_nib;
  logic       at_q4;
  assign chk_sum9 = {1'b0, acc} + {1'b0, opnd};
  assign chk_nib  = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]};
  assign at_q4    = (state == cise_pkg::ST_Q4);

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rstn);

  sequence s_phases;
    state == cise_pkg::ST_Q2 ##1 state == cise_pkg::ST_Q3 ##1 state == cise_pkg::ST_Q4;
  endsequence

  // first bubble cycle: pc has just taken the branch target
  sequence s_quiet;
    bubble && $stable(acc) && $stable(c) && $stable(dc) && $stable(z);
  endsequence

  // later bubble cycles: no fetch, so pc holds too
  sequence s_still;
    bubble && $stable(acc) && $stable(c) && $stable(dc) && $stable(z) && $stable(pc);
  endsequence

  chk_add_literal_to_acc_sum: assert property (
    (at_q4 && op_q == cise_pkg::OP_ADD_LITERAL_TO_ACC)
      |=> acc == $past(acc) + $past(instr[7:0]))
    else $error("literal add result wrong");

  chk_and_literal_with_acc_zero: assert property (
    (at_q4 && op_q == cise_pkg::OP_AND_LITERAL_WITH_ACC)
      |=> acc == ($past(acc) & $past(instr[7:0])) && z == (acc == 8'h00) && $stable(c))
    else $error("literal and wrong");

  chk_add_acc_and_file_flags: assert property (
    (at_q4 && op_q == cise_pkg::OP_ADD_ACC_AND_FILE)
      |=> c == $past(chk_sum9[8]) && dc == $past(chk_nib[4]) && z == ($past(chk_sum9[7:0]) == 8'h00))
    else $error("file add flags wrong");

  chk_dest_file: assert property (
    (at_q4 && is_file_op(op_q) && instr[cise_pkg::DEST_BIT])
      |=> file_mem[$past(fsel)] == $past(result) && $stable(acc))
    else $error("file destination not written");

  chk_and_acc_with_file_route: assert property (
    (at_q4 && op_q == cise_pkg::OP_AND_ACC_WITH_FILE && !instr[cise_pkg::DEST_BIT])
      |=> acc == ($past(acc) & $past(opnd)) && $stable(c) && $stable(dc))
    else $error("file and wrong");

  chk_or_acc_with_file_zero: assert property (
    (at_q4 && op_q == cise_pkg::OP_OR_ACC_WITH_FILE && !instr[cise_pkg::DEST_BIT])
      |=> acc == ($past(acc) | $past(opnd)) && z == (acc == 8'h00))
    else $error("file or wrong");

  chk_increment_file_result: assert property (
    (at_q4 && op_q == cise_pkg::OP_INCREMENT_FILE && !instr[cise_pkg::DEST_BIT])
      |=> acc == $past(opnd) + 8'h01 && $stable(c))
    else $error("increment wrong");

  chk_branch_target: assert property (
    (at_q4 && op_q == cise_pkg::OP_UNCONDITIONAL_BRANCH)
      |=> pc == {$past(latch[4:3]), $past(instr[10:0])})
    else $error("branch target wrong");

  chk_branch_bubble: assert property (
    (at_q4 && op_q == cise_pkg::OP_UNCONDITIONAL_BRANCH && run && !apb_wr)
      |=> s_quiet ##1 s_still[*3])
    else $error("branch second cycle not idle");

  chk_phase_order: assert property (
    (state == cise_pkg::ST_Q1) |=> s_phases)
    else $error("phase order broken");

  chk_decode_word: assert property (
    (state == cise_pkg::ST_Q1 && !bubble)
      |=> instr == $past(i_pm_data) && op_q == decode_op(instr) && pc == $past(pc) + 13'h0001)
    else $error("fetch or decode wrong");
endmodule

// ===== cise_core_tb_top.sv
`timescale 1ns/1ps
module cise_core_tb_top;
  logic        ref_clk;
  logic        rstn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [13:0] pm_data;
  logic [12:0] pm_addr;
  logic [12:0] prev;
  int          num_errors;
  int          n_checks;
  int          cyc;
  int          chg[$];

  initial ref_clk = 1'b0;
  always #50 ref_clk = ~ref_clk;

  cise_core DUT (
    .i_ref_clk (ref_clk),
    .i_rstn    (rstn),
    .i_psel    (psel),
    .i_penable (penable),
    .i_pwrite  (pwrite),
    .i_paddr   (paddr),
    .i_pwdata  (pwdata),
    .o_prdata  (prdata),
    .o_pready  (pready),
    .o_pslverr (pslverr),
    .i_pm_data (pm_data),
    .o_pm_addr (pm_addr)
  );

  cise_pmem PM (
    .i_addr (pm_addr),
    .o_data (pm_data)
  );

  // cycle stamps of every program counter change
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (pm_addr !== prev) begin
      chg.push_back(cyc);
    end
    prev <= pm_addr;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    check(r, exp);
    check({31'h0, e}, 32'h0);
  endtask

  task automatic wrf(input logic [7:0] a, input logic [31:0] d);
    wr(cise_pkg::REG_FADDR, {24'h0, a});
    wr(cise_pkg::REG_FDATA, d);
  endtask

  task automatic rdf(input logic [7:0] a, input logic [31:0] exp);
    wr(cise_pkg::REG_FADDR, {24'h0, a});
    rd(cise_pkg::REG_FDATA, exp);
  endtask

  task automatic prog(input logic [13:0] w[$]);
    foreach (w[i]) PM.load(13'(i), w[i]);
  endtask

  // program ends in a branch to itself, so the final pc is known
  task automatic run_prog(input int n);
    wr(cise_pkg::REG_CTRL, 32'h1);
    repeat (4 * n + 24) @(posedge ref_clk);
    wr(cise_pkg::REG_CTRL, 32'h0);
    repeat (12) @(posedge ref_clk);
  endtask

  task automatic reset_dut;
    rstn <= 1'b0;
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    tally_and_finish;
  end

  initial begin
    logic [31:0] r;
    logic        e;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    prev = 13'h0000;
    cyc = 0;
    reset_dut;
    rd(cise_pkg::REG_ACC, 32'h0);
    rd(cise_pkg::REG_STATUS, 32'h0);
    rd(cise_pkg::REG_PC, 32'h0);
    rd(cise_pkg::REG_LATCH, 32'h0);
    rd(cise_pkg::REG_CTRL, 32'h0);
    wr(cise_pkg::REG_STATUS, 32'h7);
    rd(cise_pkg::REG_STATUS, 32'h0);
    apb(1'b0, 8'h20, 32'h0, r, e);
    check({31'h0, e}, 32'h1);
    check(r, 32'h0);
    $display("test registers done");
    // add literal, both encodings of the don't-care bit
    prog('{14'h3E15, 14'h3FDB, 14'h2802});
    wr(cise_pkg::REG_ACC, 32'h10);
    run_prog(3);
    rd(cise_pkg::REG_ACC, 32'h00);
    rd(cise_pkg::REG_STATUS, 32'h07);
    $display("test add_literal done");
    // and literal keeps carry flags from the add before it
    reset_dut;
    prog('{14'h3EA4, 14'h395F, 14'h3900, 14'h2803});
    wr(cise_pkg::REG_ACC, 32'hFF);
    run_prog(4);
    rd(cise_pkg::REG_ACC, 32'h00);
    rd(cise_pkg::REG_STATUS, 32'h07);
    $display("test and_literal done");
    // file register operations with both destinations
    reset_dut;
    wrf(8'h10, 32'hC2);
    wrf(8'h20, 32'h13);
    wrf(8'h7F, 32'hFF);
    wrf(8'h30, 32'hED);
    wr(cise_pkg::REG_ACC, 32'h17);
    prog('{14'h0710, 14'h0590, 14'h0420, 14'h0A20, 14'h0AFF, 14'h07B0, 14'h2806});
    run_prog(7);
    rd(cise_pkg::REG_ACC, 32'h14);
    rdf(8'h10, 32'hC0);
    rdf(8'h20, 32'h13);
    rdf(8'h7F, 32'h00);
    rdf(8'h30, 32'h01);
    rd(cise_pkg::REG_STATUS, 32'h03);
    $display("test file_ops done");
    // branch with upper latch, bubble and flag preservation
    reset_dut;
    wr(cise_pkg::REG_LATCH, 32'h1F);
    wr(cise_pkg::REG_ACC, 32'hFF);
    prog('{14'h3E01, 14'h2805, 14'h3E01});
    PM.load(13'h1805, 14'h2805);
    PM.load(13'h1806, 14'h3E01);
    chg.delete();
    run_prog(3);
    if (chg.size() < 5) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, chg.size(), 32'h00000005);
    end else begin
      check(32'(chg[1] - chg[0]), 32'h00000004);
      check(32'(chg[4] - chg[2]), 32'h00000008);
    end
    rd(cise_pkg::REG_PC, 32'h1805);
    rd(cise_pkg::REG_ACC, 32'h00);
    rd(cise_pkg::REG_STATUS, 32'h07);
    rd(cise_pkg::REG_INSTR, 32'h2805);
    $display("test branch done");
    tally_and_finish;
  end
endmodule

// ===== cise_pkg.sv
// Functional notes
// - A word 11 111x plus an 8-bit literal adds the literal to the accumulator, x ignored.
// - A word 11 1001 plus a literal ANDs it into the accumulator and updates only zero.
// - A word 00 0111 d f adds accumulator and file register, updating carry, digit carry, zero.
// - File-register results go to the accumulator when d is 0 and to the file register when 1.
// - A word 00 0101 d f ANDs accumulator with the file register, routed by d, zero only.
// - A word 00 0100 d f ORs accumulator with the file register, routed by d, zero only.
// - A word 00 1010 d f adds one to the file register, routed by d, zero only.
// - A word 10 1 plus 11 bits loads pc bits 10:0 and copies latch bits 4:3 into pc bits 12:11.
// - The branch takes two cycles, the second doing nothing, and touches no flag.
// - Each single-cycle instruction runs decode, read, process and write in four phases.
package cise_pkg;
  localparam int ACC_W   = 8;
  localparam int INSTR_W = 14;
  localparam int PC_W    = 13;
  localparam int FADDR_W = 7;
  localparam int LATCH_W = 5;
  localparam int FILE_DEPTH = 128;

  // instruction fields
  localparam int DEST_BIT   = 7;
  localparam int LIT_MSB    = 7;
  localparam int FADDR_MSB  = 6;
  localparam int BR_MSB     = 10;
  localparam int LATCH_HI   = 4;
  localparam int LATCH_LO   = 3;

  // opcode patterns
  localparam logic [4:0] OPC_ADD_LIT  = 5'h1F;
  localparam logic [5:0] OPC_AND_LIT  = 6'h39;
  localparam logic [5:0] OPC_ADD_FILE = 6'h07;
  localparam logic [5:0] OPC_AND_FILE = 6'h05;
  localparam logic [5:0] OPC_OR_FILE  = 6'h04;
  localparam logic [5:0] OPC_INC_FILE = 6'h0A;
  localparam logic [2:0] OPC_BRANCH   = 3'h5;

  // register offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ACC    = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_PC     = 8'h0C;
  localparam logic [7:0] REG_LATCH  = 8'h10;
  localparam logic [7:0] REG_FADDR  = 8'h14;
  localparam logic [7:0] REG_FDATA  = 8'h18;
  localparam logic [7:0] REG_INSTR  = 8'h1C;

  // bit positions
  localparam int CTRL_RUN = 0;
  localparam int STAT_C   = 0;
  localparam int STAT_DC  = 1;
  localparam int STAT_Z   = 2;

  // reset values
  localparam logic [ACC_W-1:0]   ACC_RST   = 8'h00;
  localparam logic [PC_W-1:0]    PC_RST    = 13'h0000;
  localparam logic [LATCH_W-1:0] LATCH_RST = 5'h00;
  localparam logic [INSTR_W-1:0] INSTR_RST = 14'h0000;

  typedef enum logic [2:0] {
    OP_NONE               = 3'b000,
    OP_ADD_LITERAL_TO_ACC = 3'b001,
    OP_AND_LITERAL_WITH_ACC = 3'b010,
    OP_ADD_ACC_AND_FILE   = 3'b011,
    OP_AND_ACC_WITH_FILE  = 3'b100,
    OP_OR_ACC_WITH_FILE   = 3'b101,
    OP_INCREMENT_FILE     = 3'b110,
    OP_UNCONDITIONAL_BRANCH = 3'b111
  } cise_op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_Q1   = 3'b001,
    ST_Q2   = 3'b010,
    ST_Q3   = 3'b011,
    ST_Q4   = 3'b100
  } cise_state_t;
endpackage

// ===== cise_pmem.sv
`timescale 1ns/1ps
module cise_pmem (
  input  wire logic [cise_pkg::PC_W-1:0]    i_addr,
  output logic      [cise_pkg::INSTR_W-1:0] o_data
);
  // unwritten words hold an add-literal, so a stray fetch changes the accumulator
  logic [cise_pkg::INSTR_W-1:0] mem [0:8191];

  initial begin
    foreach (mem[i]) mem[i] = 14'h3FFF;
  end

  // one whole word per program address
  assign o_data = mem[i_addr];

  task automatic load(input logic [cise_pkg::PC_W-1:0]    a,
                      input logic [cise_pkg::INSTR_W-1:0] w);
    mem[a] = w;
  endtask
endmodule
